// ### hw/nvb_ctrl.sv
// design: byte-wide non-volatile array controller with asynchronous program timer
module nvb_ctrl
  import nvb_pkg::*;
#(
  parameter int PROG_CYCLES = NVB_PROG_CYCLES
) (
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  input  wire nvb_req_t    req_i,
  input  wire logic        bank_sel_i,
  input  wire logic [7:0]  indirect_ptr_i,
  input  wire logic        global_irq_enable_i,
  input  wire logic        nv_irq_enable_i,
  input  wire logic        group_irq_enable_i,
  input  wire logic        stack_full_i,
  input  wire logic        irq_service_i,
  output logic [7:0]       nv_byte_index_o,
  output logic [7:0]       nv_byte_value_o,
  output logic [7:0]       nv_control_o,
  output logic             nv_irq_flag_o,
  output logic             group_irq_flag_o,
  output logic             irq_vector_o,
  output logic             busy_o
);

  nvb_regs_t r;
  nvb_regs_t next_r;
  logic [7:0] mem [NVB_DEPTH];
  logic       ctrl_hit;
  logic       mem_we;
  logic       prog_done_raw;
  logic [15:0] tmr;
  logic        tmr_done;
  logic        tmr_run;

  //////////////////////////////////////////////////////////////////////////////
  // control register reachable only through bank 1 pointer at 40H
  assign ctrl_hit = req_i.wr_ctrl && bank_sel_i && (indirect_ptr_i == NVB_CTRL_OFFSET);

  //////////////////////////////////////////////////////////////////////////////
  // program timer: free of the register logic, reports done as a level
  // that is caught through a synchroniser
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tmr      <= 16'h0000;
      tmr_done <= 1'b0;
      tmr_run  <= 1'b0;
    end else if (r.prog_go && !tmr_run && !tmr_done) begin
      tmr_run <= 1'b1;
      tmr     <= 16'h0000;
    end else if (tmr_run) begin
      if (tmr == 16'(PROG_CYCLES - 1)) begin
        tmr_run  <= 1'b0;
        tmr_done <= 1'b1;
      end else begin
        tmr <= tmr + 16'h0001;
      end
    end else if (!r.prog_go) begin
      tmr_done <= 1'b0;
    end
  end
  assign prog_done_raw = tmr_done;

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_r        = r;
    mem_we        = 1'b0;
    next_r.sync1  = prog_done_raw;
    next_r.sync2  = r.sync1;
    next_r.sync3  = r.sync2;

    if (req_i.wr_index) begin
      next_r.index = req_i.wdata[5:0];
    end
    if (req_i.wr_value) begin
      next_r.value = req_i.wdata;
    end

    if (ctrl_hit) begin
      next_r.ctrl[NVB_BIT_STORE_EN] = req_i.wdata[NVB_BIT_STORE_EN];
      next_r.ctrl[NVB_BIT_FETCH_EN] = req_i.wdata[NVB_BIT_FETCH_EN];
      if (r.state == NVB_IDLE) begin
        // starts only honoured if the enable was set before this write
        if (req_i.wdata[NVB_BIT_STORE_GO] && r.ctrl[NVB_BIT_STORE_EN]) begin
          next_r.ctrl[NVB_BIT_STORE_GO] = 1'b1;
          next_r.state = NVB_STORE;
          next_r.prog_go = 1'b1;
        end else if (req_i.wdata[NVB_BIT_FETCH_GO] && r.ctrl[NVB_BIT_FETCH_EN]) begin
          next_r.ctrl[NVB_BIT_FETCH_GO] = 1'b1;
          next_r.state = NVB_FETCH;
          next_r.rd_cnt = 8'h00;
        end
      end
    end

    case (r.state)
      NVB_IDLE: begin
      end
      NVB_FETCH: begin
        next_r.rd_cnt = r.rd_cnt + 8'h01;
        if (r.rd_cnt == 8'(NVB_READ_CYCLES - 1)) begin
          next_r.value = mem[r.index];
          next_r.ctrl[NVB_BIT_FETCH_GO] = 1'b0;
          next_r.state = NVB_IDLE;
        end
      end
      NVB_STORE: begin
        if (r.sync2 && !r.sync3) begin
          mem_we = 1'b1;
          next_r.prog_go = 1'b0;
          next_r.ctrl[NVB_BIT_STORE_GO] = 1'b0;
          next_r.state = NVB_IDLE;
          next_r.done_flag = 1'b1;
          next_r.group_flag = 1'b1;
        end
      end
      default: begin
        next_r.state = NVB_IDLE;
      end
    endcase

    // set wins over clear for both flags
    if (req_i.clr_flag && !(mem_we)) begin
      next_r.done_flag = 1'b0;
    end
    if (irq_service_i && !(mem_we)) begin
      next_r.group_flag = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r.state      <= NVB_IDLE;
      r.ctrl       <= NVB_CTRL_RESET;
      r.index      <= NVB_INDEX_RESET;
      r.value      <= NVB_BYTE_RESET;
      r.rd_cnt     <= 8'h00;
      r.prog_go    <= 1'b0;
      r.sync1      <= 1'b0;
      r.sync2      <= 1'b0;
      r.sync3      <= 1'b0;
      r.done_flag  <= 1'b0;
      r.group_flag <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // array write: one byte per programming cycle
  always_ff @(posedge ref_clk_i) begin
    if (mem_we) begin
      mem[r.index] <= r.value;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  assign nv_byte_index_o  = {2'b00, r.index};
  assign nv_byte_value_o  = r.value;
  assign nv_control_o     = {4'h0, r.ctrl};
  assign nv_irq_flag_o    = r.done_flag;
  assign group_irq_flag_o = r.group_flag;
  assign busy_o           = (r.state != NVB_IDLE);
  assign irq_vector_o     = global_irq_enable_i && nv_irq_enable_i && group_irq_enable_i
                            && !stack_full_i && r.group_flag && r.done_flag;

endmodule : nvb_ctrl

// ### common/nvb_pkg.sv
// package: constants and types for the byte-wide non-volatile array controller
// Behaviour
// - array of 64 bytes, reached only via registers, one byte per operation
// - index register has six writable bits; bits 7..6 read as zero
// - value register is eight-bit read/write: write data and read result
// - control register sits at 40H of bank 1; software points there first
// - control bit 3 is store enable; cleared inhibits programming
// - control bit 2 starts programming; hardware clears it when finished
// - programming start ignored unless store enable was already set
// - control bit 1 is fetch enable; cleared inhibits reads
// - control bit 0 starts a read; hardware clears it when finished
// - read start ignored unless fetch enable was already set
// - fetched byte stays in value register until next read or program
// - programming timed by an asynchronous internal timer, delay undefined
// - power-on clears store enable so no programming occurs
// - programming end sets completion flag and group flag
// - vector only when global, array, group enables set, stack not full
// - service clears only the group flag; software clears completion flag
// - bank selector bit 0 chooses bank; resets to bank 0
package nvb_pkg;
  localparam int          NVB_DEPTH        = 64;
  localparam int          NVB_AW           = 6;
  localparam logic [7:0]  NVB_CTRL_OFFSET  = 8'h40;
  localparam logic [7:0]  NVB_BANK_CTRL    = 8'h01;
  localparam int          NVB_BIT_STORE_EN = 3;
  localparam int          NVB_BIT_STORE_GO = 2;
  localparam int          NVB_BIT_FETCH_EN = 1;
  localparam int          NVB_BIT_FETCH_GO = 0;
  localparam logic [3:0]  NVB_CTRL_RESET   = 4'h0;
  localparam logic [7:0]  NVB_BYTE_RESET   = 8'h00;
  localparam logic [5:0]  NVB_INDEX_RESET  = 6'h00;
  localparam int          NVB_READ_CYCLES  = 2;
  localparam int          NVB_PROG_CYCLES  = 16;

  typedef enum logic [2:0] {
    NVB_IDLE  = 3'b001,
    NVB_FETCH = 3'b010,
    NVB_STORE = 3'b100
  } nvb_state_t;

  // software-side register write strobes, write data and flag clear
  typedef struct packed {
    logic       wr_index;
    logic       wr_value;
    logic       wr_ctrl;
    logic [7:0] wdata;
    logic       clr_flag;
  } nvb_req_t;

  typedef struct packed {
    nvb_state_t state;
    logic [3:0] ctrl;
    logic [5:0] index;
    logic [7:0] value;
    logic [7:0] rd_cnt;
    logic       prog_go;
    logic       sync1;
    logic       sync2;
    logic       sync3;
    logic       done_flag;
    logic       group_flag;
  } nvb_regs_t;
endpackage : nvb_pkg

// ### tb/nvb_ctrl_props.sv
// checker: port-level assertions for the byte-wide array controller
module nvb_ctrl_props
  import nvb_pkg::*;
#(parameter int PROG_CYCLES = NVB_PROG_CYCLES) (
  input wire logic       ref_clk_i,
  input wire logic       resetn_i,
  input wire nvb_req_t   req_i,
  input wire logic       bank_sel_i,
  input wire logic [7:0] indirect_ptr_i,
  input wire logic       irq_service_i,
  input wire logic [7:0] nv_byte_index_o,
  input wire logic [7:0] nv_control_o,
  input wire logic       nv_irq_flag_o,
  input wire logic       group_irq_flag_o,
  input wire logic       busy_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  AST_IDX_WR: assert property (req_i.wr_index |=> nv_byte_index_o == {2'b00, $past(req_i.wdata[5:0])})
    else $error("index write wrong");
  AST_BANK: assert property ((req_i.wr_ctrl && (!bank_sel_i || indirect_ptr_i != NVB_CTRL_OFFSET))
    |=> $stable({nv_control_o[3], nv_control_o[1]})) else $error("control write not gated");
  AST_STORE_GATE: assert property ($rose(nv_control_o[2]) |-> $past(nv_control_o[3]))
    else $error("store start without enable");
  AST_FETCH_GATE: assert property ($rose(nv_control_o[0]) |-> $past(nv_control_o[1]))
    else $error("fetch start without enable");
  AST_FETCH_END: assert property ($rose(nv_control_o[0]) |=> nv_control_o[0] ##1 !nv_control_o[0])
    else $error("fetch start not cleared on time");
  AST_STORE_END: assert property ($rose(nv_control_o[2]) |-> ##[2:100] !nv_control_o[2])
    else $error("store never finished");
  AST_FLAGS: assert property ($fell(nv_control_o[2]) |-> nv_irq_flag_o && group_irq_flag_o)
    else $error("flags not set at store end");
  AST_BUSY: assert property (nv_control_o[2] |=> !$rose(nv_control_o[0]))
    else $error("fetch started while storing");
  AST_SVC: assert property (irq_service_i && !busy_o |=> !group_irq_flag_o && nv_irq_flag_o == $past(nv_irq_flag_o))
    else $error("service cleared wrong flag");
endmodule : nvb_ctrl_props
////////////////////////////////////////////////////////////
bind nvb_ctrl nvb_ctrl_props #(.PROG_CYCLES(PROG_CYCLES)) u_props (.ref_clk_i, .resetn_i, .req_i, .bank_sel_i,
  .indirect_ptr_i, .irq_service_i, .nv_byte_index_o, .nv_control_o, .nv_irq_flag_o, .group_irq_flag_o, .busy_o);

// ### tb/tb_top.sv
// testbench: random and corner register traffic for the byte-wide array controller
module tb_top;
  import nvb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, rst_n, bank, sf, svc, ge, nvf, grf, vec, busy;
  logic [7:0] ptr, lf, idx, vl, idx_o, val_o, ctl_o;
  logic [7:0] mem [64];
  nvb_req_t   req;
  int         error_cnt, n_checks, i;
  nvb_ctrl #(.PROG_CYCLES(4)) u_dut (.ref_clk_i(clk), .resetn_i(rst_n), .req_i(req), .bank_sel_i(bank),
    .indirect_ptr_i(ptr), .global_irq_enable_i(ge), .nv_irq_enable_i(ge), .group_irq_enable_i(ge),
    .stack_full_i(sf), .irq_service_i(svc), .nv_byte_index_o(idx_o), .nv_byte_value_o(val_o),
    .nv_control_o(ctl_o), .nv_irq_flag_o(nvf), .group_irq_flag_o(grf), .irq_vector_o(vec), .busy_o(busy));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // k selects strobes {index, value, ctrl, clear flag}
  task automatic wr(input logic [3:0] k, input logic [7:0] d);
    @(negedge clk);
    {req.wr_index, req.wr_value, req.wr_ctrl, req.clr_flag} = k;
    req.wdata = d;
    @(negedge clk);
    req = '0;
  endtask : wr
  // first draw is a corner: upper index bits set, landing on location 63
  task automatic gen(input int n);
    lf = lfsr(lf);
    idx = (n == 0) ? 8'hff : lf;
    lf = lfsr(lf);
    vl = lf;
  endtask : gen
  task automatic test_done();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  // whole run needs well under 2000 cycles
  initial begin
    #100000;
    error_cnt++;
    test_done();
  end
  initial begin
    {rst_n, bank, sf, svc, ge, req} = '0;
    ptr = NVB_CTRL_OFFSET;
    lf = 8'h27;
    repeat (4) @(negedge clk);
    rst_n = 1;
    chk(ctl_o, 8'h00);
    chk(idx_o, 8'h00);
    chk(val_o, 8'h00);
    wr(2, 8'h08);
    chk(ctl_o, 8'h00);
    bank = 1;
    ge = 1;
    wr(2, 8'h04);
    chk(ctl_o, 8'h00);
    wr(2, 8'h01);
    chk(ctl_o, 8'h00);
    $display("test refusals done");
    for (i = 0; i < 6; i++) begin
      gen(i);
      wr(8, idx);
      chk(idx_o, {2'b00, idx[5:0]});
      wr(4, vl);
      chk(val_o, vl);
      ge = 0;
      wr(2, 8'h0a);
      wr(2, 8'h0e);
      ge = 1;
      chk(ctl_o, 8'h0e);
      chk(busy, 8'h01);
      // fetch start while storing, fetch enable already set: must be ignored
      wr(2, 8'h0b);
      chk(ctl_o, 8'h0e);
      repeat (100) if (ctl_o[2]) @(negedge clk);
      chk(ctl_o, 8'h0a);
      chk(busy, 8'h00);
      chk({nvf, grf, vec}, 3'b111);
      sf = 1;
      #1 chk(vec, 8'h00);
      @(negedge clk);
      sf = 0;
      svc = 1;
      @(negedge clk);
      svc = 0;
      chk({nvf, grf}, 2'b10);
      wr(1, 8'h00);
      chk(nvf, 0);
      mem[idx[5:0]] = vl;
    end
    $display("test stores done");
    lf = 8'h27;
    for (i = 0; i < 6; i++) begin
      gen(i);
      wr(8, idx);
      wr(2, 8'h02);
      wr(2, 8'h03);
      chk(ctl_o, 8'h03);
      repeat (2) @(negedge clk);
      chk(ctl_o, 8'h02);
      chk(val_o, mem[idx[5:0]]);
      repeat (3) @(negedge clk);
      chk(val_o, mem[idx[5:0]]);
    end
    $display("test fetches done");
    test_done();
  end
endmodule : tb_top
